// File: sqd_decoder.sv
// sqd_decoder: spi command front end of an eight channel squib driver.
// assumes an spi master drives sclk, cs_n and mosi; ref_clk runs at 25 MHz
// and chip select stays high for at least four ref_clk cycles between frames.
module sqd_decoder
  import sqd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  output logic [1:0]      fire_current_level,
  output logic [1:0]      fire_permit_latch,
  output logic            power_up_flag,
  output logic            cmd_strobe,
  output logic [1:0]      cmd_group,
  output logic            arm_strobe,
  output logic            fire_strobe,
  output logic [7:0]      channel_select,
  output logic [2:0]      diag_select,
  output logic [1:0]      monitor_select,
  output logic            soft_reset_pulse
);

  // parity insertion for outgoing words
  function automatic logic [WORD_W-1:0] with_parity(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] r;
    r          = w;
    r[PAR_BIT] = 1'b0;
    r[PAR_BIT] = ~(^r);
    return r;
  endfunction : with_parity

  sqd_state_t        state;
  sqd_state_t        next_state;
  logic [WORD_W-1:0] rx_word;
  logic [CNT_W-1:0]  rx_count;
  logic              rx_tag;
  logic              ack_tag;
  logic              next_ack_tag;
  logic              cs_sync;
  logic              cs_prev;
  logic              cs_rise;
  logic [WORD_W-1:0] frame_word;
  logic [WORD_W-1:0] next_frame_word;
  logic [CNT_W-1:0]  frame_cnt;
  logic [CNT_W-1:0]  next_frame_cnt;
  logic              frame_empty;
  logic              next_frame_empty;
  logic [WORD_W-1:0] resp_word;
  logic [WORD_W-1:0] next_resp_word;
  logic [1:0]        next_level;
  logic [1:0]        next_latch;
  logic              next_pu;
  logic              srst_armed;
  logic              next_srst_armed;
  logic              next_cmd_strobe;
  logic [1:0]        next_cmd_group;
  logic              next_arm_strobe;
  logic              next_fire_strobe;
  logic [7:0]        next_channel;
  logic [2:0]        next_diag;
  logic [1:0]        next_monitor;
  logic              next_soft_reset;
  logic              count_ok;
  logic              parity_ok;
  logic              code_ok;
  logic              do_srst;
  logic [1:0]        grp;
  logic [4:0]        sub;
  logic [7:0]        low_byte;

  // link side shifter on the host clock
  sqd_spi_link u_link (
    .spi_sclk (spi_sclk),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .tx_word  (resp_word),
    .ack_tag  (ack_tag),
    .rx_word  (rx_word),
    .rx_count (rx_count),
    .rx_tag   (rx_tag),
    .spi_miso (spi_miso)
  );

  // chip select level into the ref_clk domain; idles high
  sqd_sync2 #(
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (spi_cs_n),
    .sync_out (cs_sync)
  );

  // end of frame seen on the synchronised level only
  assign cs_rise     = cs_sync & ~cs_prev;
  assign spi_miso_oe = ~spi_cs_n;  // drive miso only inside a frame

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cs_prev <= 1'b1;
    else
      cs_prev <= cs_sync;
  end

  // field views of the captured frame
  assign grp      = frame_word[GRP_HI:GRP_LO];
  assign sub      = frame_word[SUB_HI:SUB_LO];
  assign low_byte = frame_word[BYTE_HI:0];

  // checks on the captured frame
  always_comb
  begin
    count_ok  = !frame_empty && (frame_cnt == BITS_FULL);
    parity_ok = ^frame_word;
    code_ok   = (grp != GRP_DEPLOY) || (sub == ARM_CODE) ||
                (sub == FIRE_CODE);
    do_srst   = (grp == GRP_CFG) && !frame_word[SEL_BIT] &&
                frame_word[RW_BIT] && frame_word[SWR_BIT] &&
                srst_armed && (low_byte == SRST_SECOND);
  end

  // decoder next state: capture on frame end, evaluate one cycle later
  always_comb
  begin
    next_state       = state;
    next_frame_word  = frame_word;
    next_frame_cnt   = frame_cnt;
    next_frame_empty = frame_empty;
    next_ack_tag     = ack_tag;
    next_resp_word   = resp_word;
    next_level       = fire_current_level;
    next_latch       = fire_permit_latch;
    next_pu          = power_up_flag;
    next_srst_armed  = srst_armed;
    next_cmd_strobe  = 1'b0;
    next_cmd_group   = cmd_group;
    next_arm_strobe  = 1'b0;
    next_fire_strobe = 1'b0;
    next_channel     = channel_select;
    next_diag        = diag_select;
    next_monitor     = monitor_select;
    next_soft_reset  = 1'b0;
    case (state)
      ST_IDLE:
      begin
        // link registers are quiet once chip select is high, so the
        // words are taken as they stand after the level synchroniser
        if (cs_rise)
        begin
          next_frame_word  = rx_word;
          next_frame_cnt   = rx_count;
          // an unchanged tag means the frame brought no clocks; ack_tag only
          // moves while chip select is high, so the link sees it settled
          next_frame_empty = (rx_tag == ack_tag);
          next_ack_tag     = rx_tag;
          next_state       = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        next_state      = ST_IDLE;
        next_pu         = 1'b1;
        next_srst_armed = 1'b0;
        if (!count_ok)
          next_resp_word = RESP_CNTERR;
        else if (!parity_ok || !code_ok)
          next_resp_word = RESP_PARERR;
        else if (do_srst)
        begin
          // every stored setting returns to its power-on value; the answer is RESP_SRST and power_up_flag stays set
          next_level      = LEVEL_RST;
          next_latch      = LATCH_RST;
          next_cmd_group  = GRP_CFG;
          next_channel    = CHAN_RST;
          next_diag       = DIAG_RST;
          next_monitor    = MON_RST;
          next_soft_reset = 1'b1;
          next_resp_word  = RESP_SRST;
        end
        else
        begin
          next_cmd_strobe = 1'b1;
          next_cmd_group  = grp;
          next_resp_word  = frame_word;  // other groups echo the command
          case (grp)
            GRP_CFG:
            begin
              if (!frame_word[SEL_BIT])
              begin
                // mode 1: a read leaves every setting alone
                if (frame_word[RW_BIT])
                begin
                  if (!frame_word[SWR_BIT])
                    next_level = frame_word[LVL_HI:LVL_LO];
                  else if (low_byte == SRST_FIRST)
                    next_srst_armed = 1'b1;
                end
                // 0x1X02 or 0x3X02 after the first reset word falls out of this form
                next_resp_word = with_parity({GRP_CFG, 1'b0,
                  frame_word[RW_BIT], frame_word[SWR_BIT], 1'b0, next_level,
                  6'h00, next_pu, 1'b0});
              end
              else
              begin
                // mode 2: fire permit latch time
                if (frame_word[RW_BIT])
                  next_latch = frame_word[LVL_HI:LVL_LO];
                next_resp_word = with_parity({GRP_CFG, 1'b0,
                  frame_word[RW_BIT], 1'b0, 1'b1, next_latch, 8'h00});
              end
            end
            GRP_DEPLOY:
            begin
              next_arm_strobe  = (sub == ARM_CODE);
              next_fire_strobe = (sub == FIRE_CODE);
              next_channel     = low_byte;
            end
            GRP_DIAG:
            begin
              next_diag = frame_word[DIAG_HI:DIAG_LO];
            end
            default:
            begin
              next_monitor = frame_word[MON_HI:MON_LO];
            end
          endcase
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // decoder registers; the response register feeds the next frame
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state              <= ST_IDLE;
      frame_word         <= RESP_RESET;
      frame_cnt          <= '0;
      frame_empty        <= 1'b1;
      ack_tag            <= 1'b0;
      resp_word          <= RESP_RESET;
      fire_current_level <= LEVEL_RST;
      fire_permit_latch  <= LATCH_RST;
      power_up_flag      <= 1'b0;
      srst_armed         <= 1'b0;
      cmd_strobe         <= 1'b0;
      cmd_group          <= GRP_CFG;
      arm_strobe         <= 1'b0;
      fire_strobe        <= 1'b0;
      channel_select     <= CHAN_RST;
      diag_select        <= DIAG_RST;
      monitor_select     <= MON_RST;
      soft_reset_pulse   <= 1'b0;
    end
    else
    begin
      state              <= next_state;
      frame_word         <= next_frame_word;
      frame_cnt          <= next_frame_cnt;
      frame_empty        <= next_frame_empty;
      ack_tag            <= next_ack_tag;
      resp_word          <= next_resp_word;
      fire_current_level <= next_level;
      fire_permit_latch  <= next_latch;
      power_up_flag      <= next_pu;
      srst_armed         <= next_srst_armed;
      cmd_strobe         <= next_cmd_strobe;
      cmd_group          <= next_cmd_group;
      arm_strobe         <= next_arm_strobe;
      fire_strobe        <= next_fire_strobe;
      channel_select     <= next_channel;
      diag_select        <= next_diag;
      monitor_select     <= next_monitor;
      soft_reset_pulse   <= next_soft_reset;
    end
  end

endmodule : sqd_decoder

// File: sqd_pkg.sv
// sqd_pkg: constants shared by the squib spi command decoder files.
// assumes 16-bit spi frames with odd parity carried in one fixed bit.
package sqd_pkg;

  // frame geometry
  localparam int          WORD_W     = 16;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  BITS_FULL  = 5'h10;  // exact bit count of a good frame
  localparam logic [4:0]  BITS_SAT   = 5'h11;  // count stops here on long frames
  localparam logic [3:0]  LAST_BIT   = 4'hF;

  // field positions
  localparam int GRP_HI   = 15;
  localparam int GRP_LO   = 14;
  localparam int PAR_BIT  = 13;
  localparam int RW_BIT   = 12;
  localparam int SWR_BIT  = 11;
  localparam int SEL_BIT  = 10;
  localparam int LVL_HI   = 9;
  localparam int LVL_LO   = 8;
  localparam int SUB_HI   = 12;
  localparam int SUB_LO   = 8;
  localparam int DIAG_HI  = 11;
  localparam int DIAG_LO  = 9;
  localparam int MON_HI   = 11;
  localparam int MON_LO   = 10;
  localparam int BYTE_HI  = 7;
  localparam int PU_BIT   = 1;
  localparam int DONE_BIT = 0;

  // command groups
  localparam logic [1:0] GRP_CFG    = 2'h0;
  localparam logic [1:0] GRP_DEPLOY = 2'h1;
  localparam logic [1:0] GRP_DIAG   = 2'h2;
  localparam logic [1:0] GRP_MON    = 2'h3;

  // deployment sub codes and soft reset pattern
  localparam logic [4:0] ARM_CODE    = 5'h19;
  localparam logic [4:0] FIRE_CODE   = 5'h00;
  localparam logic [7:0] SRST_FIRST  = 8'hAA;
  localparam logic [7:0] SRST_SECOND = 8'h55;

  // reset values
  localparam logic [1:0] LEVEL_RST = 2'h0;
  localparam logic [1:0] LATCH_RST = 2'h0;
  localparam logic [7:0] CHAN_RST  = 8'h00;
  localparam logic [2:0] DIAG_RST  = 3'h0;
  localparam logic [1:0] MON_RST   = 2'h0;

  // fixed response words
  localparam logic [15:0] RESP_RESET  = 16'h0000;
  localparam logic [15:0] RESP_PARERR = 16'hD000;
  localparam logic [15:0] RESP_CNTERR = 16'hD003;
  localparam logic [15:0] RESP_SRST   = 16'h2003;

  // decoder states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EVAL = 2'b10
  } sqd_state_t;

endpackage : sqd_pkg

// File: sqd_sync2.sv
// sqd_sync2: two flip-flop level synchroniser.
// assumes the input is a slowly changing level from another domain.
module sqd_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  // first stage is read only by the second stage
  always_comb
  begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : sqd_sync2

// File: sqd_spi_link.sv
// sqd_spi_link: shift logic clocked by the host's serial clock.
// assumes mosi is sampled on rising sclk and miso changes on falling sclk;
// sclk stands still outside frames, chip select high ends a frame.
module sqd_spi_link
  import sqd_pkg::*;
(
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  input  wire logic [WORD_W-1:0] tx_word,
  input  wire logic              ack_tag,
  output logic      [WORD_W-1:0] rx_word,
  output logic      [CNT_W-1:0]  rx_count,
  output logic                   rx_tag,
  output logic                   spi_miso
);

  logic              rx_empty;
  logic              next_rx_tag;
  logic [WORD_W-1:0] next_rx_word;
  logic [CNT_W-1:0]  next_rx_count;
  logic              out_bit;
  logic              next_out_bit;

  // a frame starts fresh: chip select high presets the flag, no sclk needed
  always_ff @(posedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      rx_empty <= 1'b1;
    else
      rx_empty <= 1'b0;
  end

  // msb first shift in; count saturates so long frames stay detectable
  // the first bit also marks the frame with the inverse of ack_tag; the
  // flag above is preset by chip select, so it cannot tell an empty frame
  always_comb
  begin
    next_rx_word  = {rx_word[WORD_W-2:0], spi_mosi};
    next_rx_count = rx_count;
    next_rx_tag   = rx_tag;
    if (rx_empty)
    begin
      next_rx_count = CNT_W'(1);
      next_rx_tag   = ~ack_tag;
    end
    else if (rx_count != BITS_SAT)
      next_rx_count = rx_count + CNT_W'(1);
  end

  always_ff @(posedge spi_sclk)
  begin
    rx_word  <= next_rx_word;
    rx_count <= next_rx_count;
    rx_tag   <= next_rx_tag;
  end

  // next response bit, guarded against reading past the word
  always_comb
  begin
    next_out_bit = 1'b0;
    if (rx_count < BITS_FULL)
      next_out_bit = tx_word[LAST_BIT - rx_count[3:0]];
  end

  always_ff @(negedge spi_sclk)
  begin
    out_bit <= next_out_bit;
  end

  // msb must be on the line before the first clock edge
  assign spi_miso = rx_empty ? tx_word[WORD_W-1] : out_bit;

endmodule : sqd_spi_link

// File: sqd_host_model.sv
// sqd_host_model: spi master standing in for the host controller.
// assumes the bench calls xfer only while the decoder is between frames.
module sqd_host_model
  import sqd_pkg::*;
(
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: link clock parked low, chip select high; set just after time zero
  // so that the link's frame preset sees a real rising edge of chip select
  initial
  begin
    #1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // one frame of nbits at a 6 ns link clock; callers supply odd parity
  task automatic xfer(input logic [WORD_W-1:0] word, input int nbits,
                      output logic [WORD_W-1:0] resp);
    logic [WORD_W-1:0] sh;
    sh = word;
    resp = '0;
    spi_cs_n = 1'b0;
    #3;
    for (int i = 0; i < nbits; i++)
    begin
      spi_mosi = sh[WORD_W-1];
      sh = {sh[WORD_W-2:0], sh[WORD_W-1]};
      #3;
      resp = {resp[WORD_W-2:0], spi_miso};
      spi_sclk = 1'b1;
      #3 spi_sclk = 1'b0;
    end
    // a frame with few clocks must still last long enough for the ref_clk side
    if (nbits < 8)
      #100;
    #3 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;  // a released line must not show the last bit
  endtask : xfer
endmodule : sqd_host_model

// File: sqd_decoder_asserts.sv
// sqd_decoder_asserts: checker bound to the decoder top.
// assumes frames are spaced well apart on the ref_clk side.
module sqd_decoder_asserts
  import sqd_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       spi_sclk,
  input wire logic       spi_cs_n,
  input wire logic       spi_mosi,
  input wire logic       spi_miso,
  input wire logic       spi_miso_oe,
  input wire logic [1:0] fire_current_level,
  input wire logic [1:0] fire_permit_latch,
  input wire logic       power_up_flag,
  input wire logic       cmd_strobe,
  input wire logic [1:0] cmd_group,
  input wire logic       arm_strobe,
  input wire logic       fire_strobe,
  input wire logic [7:0] channel_select,
  input wire logic [2:0] diag_select,
  input wire logic [1:0] monitor_select,
  input wire logic       soft_reset_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_OE_FOLLOWS_CS: assert property (spi_miso_oe == !spi_cs_n)
    else $error("miso enable does not follow chip select");
  AST_ARM_IS_DEPLOY: assert property ((arm_strobe || fire_strobe)
    |-> cmd_strobe && cmd_group == GRP_DEPLOY)
    else $error("arm or fire pulse outside a deployment command");
  AST_DEPLOY_CODE: assert property (cmd_strobe && cmd_group == GRP_DEPLOY
    |-> arm_strobe != fire_strobe)
    else $error("accepted deployment command with no single code");
  AST_STROBE_PULSE: assert property (cmd_strobe |=> !cmd_strobe [*3])
    else $error("command pulse longer than one cycle");
  AST_SRST_PULSE: assert property (soft_reset_pulse
    |-> !cmd_strobe ##1 !soft_reset_pulse)
    else $error("soft reset pulse malformed");
  AST_SRST_CLEARS: assert property (soft_reset_pulse |-> ##[1:2]
    (fire_current_level == LEVEL_RST && fire_permit_latch == LATCH_RST
     && channel_select == CHAN_RST && diag_select == DIAG_RST
     && monitor_select == MON_RST))
    else $error("soft reset left a stored setting");
  AST_LEVEL_AFTER_FRAME: assert property ($changed(fire_current_level)
    |-> spi_cs_n && $past(spi_cs_n, 3))
    else $error("level changed while a frame was in flight");
  AST_PU_STICKY: assert property (power_up_flag |=> power_up_flag)
    else $error("power up flag fell without reset");
  AST_PU_WITH_CMD: assert property (cmd_strobe |-> power_up_flag)
    else $error("command accepted with power up flag low");
endmodule : sqd_decoder_asserts

bind sqd_decoder sqd_decoder_asserts i_asserts (.ref_clk, .sys_rst, .spi_sclk, .spi_cs_n,
  .spi_mosi, .spi_miso, .spi_miso_oe, .fire_current_level, .fire_permit_latch,
  .power_up_flag, .cmd_strobe, .cmd_group, .arm_strobe, .fire_strobe, .channel_select,
  .diag_select, .monitor_select, .soft_reset_pulse);

// File: sqd_decoder_tb_top.sv
// sqd_decoder_tb_top: self-checking bench for the spi command decoder.
// assumes the host model owns the link pins; expectations come from a shadow model.
module sqd_decoder_tb_top
  import sqd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              ref_clk;
  logic              sys_rst;
  wire logic         spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  wire logic [1:0]   fire_current_level, fire_permit_latch, cmd_group, monitor_select;
  wire logic         power_up_flag, cmd_strobe, arm_strobe, fire_strobe, soft_reset_pulse;
  wire logic [7:0]   channel_select;
  wire logic [2:0]   diag_select;
  int                err_count;
  int                check_count;
  int                cmd_seen = 0, arm_seen = 0, fire_seen = 0, srst_seen = 0;
  logic [31:0]       seed;
  logic [1:0]        lvl, latch;
  logic              pend;
  logic [WORD_W-1:0] exp_resp, w;
  logic [WORD_W-1:0] dir_w [20] = '{16'h0000, 16'h1300, 16'h18AA, 16'h1855, 16'h0000,
    16'h1200, 16'h18AA, 16'h1855, 16'h1855, 16'h18AA, 16'h1855, 16'h1855, 16'h1300,
    16'h1E00, 16'h1700, 16'h0400, 16'h5905, 16'h4081, 16'h4300, 16'h5905};
  int                dir_n [20] = '{16, 16, 16, 16, 16, 16, 16, 0, 16, 16, 15, 16, 0,
    16, 16, 16, 16, 16, 16, 17};

  sqd_decoder i_dut (.ref_clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .fire_current_level, .fire_permit_latch, .power_up_flag, .cmd_strobe,
    .cmd_group, .arm_strobe, .fire_strobe, .channel_select, .diag_select,
    .monitor_select, .soft_reset_pulse);
  sqd_host_model i_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // strobes are counted on the falling edge, half a cycle after their launch
  always @(negedge ref_clk)
  begin
    cmd_seen  <= cmd_seen + int'(cmd_strobe);
    arm_seen  <= arm_seen + int'(arm_strobe);
    fire_seen <= fire_seen + int'(fire_strobe);
    srst_seen <= srst_seen + int'(soft_reset_pulse);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // bit 13 makes the ones count odd
  function automatic logic [WORD_W-1:0] par(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] r;
    r = v;
    r[PAR_BIT] = 1'b0;
    r[PAR_BIT] = ~(^r);
    return r;
  endfunction : par

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // send one word, compare the answer to the previous frame, then predict
  task automatic frame(input logic [WORD_W-1:0] v, input int n);
    logic [WORD_W-1:0] r;
    logic [1:0]        g;
    logic              rw, sw, ok, hit, acc;
    logic [4:0]        sc;
    int                c0, a0, f0, s0;
    c0 = cmd_seen;
    a0 = arm_seen;
    f0 = fire_seen;
    s0 = srst_seen;
    hit = 1'b0;
    i_host.xfer(v, n, r);
    // a short or long frame only returns the bits that were clocked
    check(r, n > WORD_W ? exp_resp << (n - WORD_W) : exp_resp >> (WORD_W - n));
    repeat (8) @(posedge ref_clk);
    #2;
    g = v[GRP_HI:GRP_LO];
    rw = v[RW_BIT];
    sw = v[SWR_BIT];
    sc = v[SUB_HI:SUB_LO];
    ok = (n == WORD_W) && (^v == 1'b1);
    if (n != WORD_W)
      exp_resp = RESP_CNTERR;
    else if (!ok)
      exp_resp = RESP_PARERR;
    else if (g == GRP_CFG && v[SEL_BIT])
    begin
      if (rw)
        latch = v[LVL_HI:LVL_LO];
      exp_resp = par({3'h0, rw, 2'h1, latch, 8'h00});
    end
    else if (g == GRP_CFG)
    begin
      if (rw && !sw)
        lvl = v[LVL_HI:LVL_LO];
      if (rw && sw && pend && v[BYTE_HI:0] == SRST_SECOND)
      begin
        lvl = LEVEL_RST;
        hit = 1'b1;
        latch = LATCH_RST;
        exp_resp = RESP_SRST;
      end
      else
        exp_resp = par({3'h0, rw, sw, 1'b0, lvl, 8'h02});
    end
    else if (g == GRP_DEPLOY && v[SUB_HI:SUB_LO] != ARM_CODE && v[SUB_HI:SUB_LO] != FIRE_CODE)
      exp_resp = RESP_PARERR;
    else
      exp_resp = v;
    // any frame but another first step drops a pending first step
    pend = ok && g == GRP_CFG && !v[SEL_BIT] && rw && sw && v[BYTE_HI:0] == SRST_FIRST;
    acc = ok && !hit && (g != GRP_DEPLOY || exp_resp == v);
    ok = ok && g != GRP_CFG && exp_resp == v;
    check(16'(fire_current_level), 16'(lvl));
    check(16'(fire_permit_latch), 16'(latch));
    if (ok)
      check(16'(cmd_group), 16'(g));
    if (ok && g == GRP_DEPLOY)
      check(16'(channel_select), 16'(v[BYTE_HI:0]));
    if (ok && g == GRP_DIAG)
      check(16'(diag_select), 16'(v[DIAG_HI:DIAG_LO]));
    if (ok && g == GRP_MON)
      check(16'(monitor_select), 16'(v[MON_HI:MON_LO]));
    check(16'(srst_seen - s0), 16'(hit));
    check(16'(cmd_seen - c0), 16'(acc));
    check(16'(arm_seen - a0), 16'(acc && g == GRP_DEPLOY && sc == ARM_CODE));
    check(16'(fire_seen - f0), 16'(acc && g == GRP_DEPLOY && sc == FIRE_CODE));
  endtask : frame

  // a hang is cut short here
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    err_count = 0;
    check_count = 0;
    seed = 32'h3b006f9e;
    lvl = LEVEL_RST;
    latch = LATCH_RST;
    pend = 1'b0;
    exp_resp = RESP_RESET;
    repeat (8) @(posedge ref_clk);
    #2 sys_rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #2;
    // table: n of 0 sends the word with its parity bit turned round
    for (int i = 0; i < 20; i++)
    begin
      frame(par(dir_w[i]) ^ (dir_n[i] == 0 ? 16'h2000 : 16'h0000), dir_n[i] == 0 ? 16 : dir_n[i]);
      if (i == 0)
        check(16'(power_up_flag), 16'h0001);
    end
    // every diagnostic and monitor code, then every level code
    for (int i = 0; i < 8; i++)
      frame(par({2'h2, 2'h0, 3'(i), 9'h0A5}), 16);
    for (int i = 0; i < 4; i++)
      frame(par({2'h3, 2'h0, 2'(i), 10'h15A}), 16);
    for (int i = 0; i < 4; i++)
      frame(par({4'h1, 2'h0, 2'(i), 8'h3C}), 16);
    // random words, some broken, some steering soft reset steps
    for (int i = 0; i < 80; i++)
    begin
      seed = xs(seed);
      w = seed[15:0];
      if (w[15:14] == GRP_CFG && !w[12])
        w[11] = 1'b0;
      if (w[15:14] == GRP_CFG && w[11] && seed[16])
        w[7:0] = seed[17] ? SRST_SECOND : SRST_FIRST;
      frame(par(w) ^ (seed[26:24] == 3'h0 ? 16'h2000 : 16'h0000),
            seed[31:28] == 4'hF ? 15 + 2 * int'(seed[27]) : 16);
    end
    // a frame with no clocks is a count error and drops a pending first step
    frame(par(16'h18AA), 16);
    frame(par(16'h1855), 0);
    frame(par(16'h1855), 16);
    frame(par(16'h0000), 16);
    give_verdict();
  end
endmodule : sqd_decoder_tb_top
